// [src/event_totalizer_digital_io.sv]
// Top of the event totalizer, digital I/O and DAC code block with APB registers.
// Assumes a single 25 MHz pclk, an APB master and pads outside that resolve the ports.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module event_totalizer_digital_io
#(
    parameter logic [15:0] SLOT_BASE = totalizer_pkg::DEFAULT_SLOT
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic evt_pin,
    input wire logic [totalizer_pkg::PORT_W-1:0] port0_i,
    output logic [totalizer_pkg::PORT_W-1:0] port0_o,
    output logic [totalizer_pkg::PORT_W-1:0] port0_oe,
    input wire logic [totalizer_pkg::PORT_W-1:0] port1_i,
    output logic [totalizer_pkg::PORT_W-1:0] port1_o,
    output logic [totalizer_pkg::PORT_W-1:0] port1_oe,
    output logic [15:0] dac0_code,
    output logic [15:0] dac1_code
);
    import totalizer_pkg::*;

    logic setup;
    logic wr;
    logic rd_setup;
    logic [1:0] ctrl_reg;
    logic [1:0] dir_reg;
    logic [15:0] dac0_reg;
    logic [15:0] dac1_reg;
    logic [SCAN_CH-1:0] mask_reg;
    logic [SCAN_CH-1:0] mask_next;
    logic reject_reg;
    logic [15:0] scan_dio_reg;
    logic [COUNT_W-1:0] scan_count_reg;
    scan_state_e state_reg;
    logic [1:0] idx_reg;
    logic [31:0] prdata_reg;
    logic err_reg;
    logic [31:0] rd_mux;
    logic rd_ok;
    logic [COUNT_W-1:0] count;
    logic bus_clear;
    logic scan_clear;
    logic [PORT_W-1:0] live0;
    logic [PORT_W-1:0] live1;
    logic [15:0] list_start;
    logic [15:0] list_end;
    logic list_ok;
    logic busy;

    // ********************************************************
    // APB decode
    // ********************************************************
    // Read data and clearing side effects are taken in the setup cycle so that the
    // access phase can complete at once with prdata already in a flip-flop.
    assign setup = psel & ~penable;
    assign rd_setup = setup & ~pwrite;
    assign wr = psel & penable & pwrite;
    assign pready = psel & penable;
    assign pslverr = psel & penable & err_reg;
    assign prdata = prdata_reg;
    assign busy = (state_reg == scan_run);

    always_comb
    begin
        rd_mux = '0;
        rd_ok = 1'b1;
        case (paddr)
            CTRL_OFS: rd_mux = {30'h0, ctrl_reg};
            COUNT_OFS: rd_mux = {6'h0, count};
            COUNT_CLR_OFS: rd_mux = {6'h0, count};
            DIR_OFS: rd_mux = {30'h0, dir_reg};
            PORT0_OFS: rd_mux = {24'h0, live0};
            PORT1_OFS: rd_mux = {24'h0, live1};
            WORD_OFS: rd_mux = {16'h0, live1, live0};
            DAC0_OFS: rd_mux = {16'h0, dac0_reg};
            DAC1_OFS: rd_mux = {16'h0, dac1_reg};
            SCAN_LIST_OFS: rd_mux = {29'h0, mask_reg};
            SCAN_CTRL_OFS: rd_mux = {30'h0, reject_reg, busy};
            SCAN_DIO_OFS: rd_mux = {16'h0, scan_dio_reg};
            SCAN_COUNT_OFS: rd_mux = {6'h0, scan_count_reg};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= '0;
            err_reg <= 1'b0;
        end
        else if (setup)
        begin
            prdata_reg <= pwrite ? 32'h0 : rd_mux;
            err_reg <= ~rd_ok;
        end
    end

    // A clearing read resets the counter in the same edge that captures it.
    assign bus_clear = rd_setup && paddr == COUNT_CLR_OFS;

    // ********************************************************
    // Configuration and outputs written by software
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= CTRL_RESET;
        else if (wr && paddr == CTRL_OFS)
            ctrl_reg <= pwdata[1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dir_reg <= DIR_RESET;
        else if (wr && paddr == SCAN_LIST_OFS && list_ok && !busy)
            dir_reg <= dir_reg & ~mask_next[1:0];
        else if (wr && paddr == DIR_OFS)
            dir_reg <= pwdata[1:0];
    end

    // DAC codes change only on direct bus writes, never from the scan. 
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac0_reg <= DAC_RESET;
            dac1_reg <= DAC_RESET;
        end
        else if (wr && paddr == DAC0_OFS)
            dac0_reg <= pwdata[15:0];
        else if (wr && paddr == DAC1_OFS)
            dac1_reg <= pwdata[15:0];
    end

    assign dac0_code = dac0_reg;
    assign dac1_code = dac1_reg;

    // ********************************************************
    // Digital ports and counter
    // ********************************************************
    dio_port #(.WIDTH(PORT_W)) u_port0
    (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr && (paddr == PORT0_OFS || paddr == WORD_OFS)),
        .wr_data(pwdata[7:0]),
        .drive(dir_reg[0]),
        .pin_i(port0_i),
        .pin_o(port0_o),
        .pin_oe(port0_oe),
        .live(live0)
    );

    dio_port #(.WIDTH(PORT_W)) u_port1
    (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr && (paddr == PORT1_OFS || paddr == WORD_OFS)),
        .wr_data(paddr == WORD_OFS ? pwdata[15:8] : pwdata[7:0]),
        .drive(dir_reg[1]),
        .pin_i(port1_i),
        .pin_o(port1_o),
        .pin_oe(port1_oe),
        .live(live1)
    );

    event_counter #(.WIDTH(COUNT_W)) u_counter
    (
        .pclk(pclk),
        .presetn(presetn),
        .evt_pin(evt_pin),
        .edge_falling(ctrl_reg[CTRL_EDGE_BIT]),
        .clear(bus_clear | scan_clear),
        .count(count)
    );

    // ********************************************************
    // Scan list
    // ********************************************************
    // Channel numbers are plain binary slot plus index, e.g. 101 to 103 for slot 100.
    // Only channels 1 to 3 can be read by a scan; DAC channels never enter the mask.
    assign list_start = pwdata[15:0];
    assign list_end = pwdata[31:LIST_END_LSB];
    assign list_ok = list_start > SLOT_BASE && list_start <= SLOT_BASE + 16'(SCAN_CH)
        && list_end > SLOT_BASE && list_end <= SLOT_BASE + 16'(SCAN_CH)
        && list_start <= list_end;

    for (genvar i = 0; i < SCAN_CH; i++)
    begin : g_mask
        assign mask_next[i] = (SLOT_BASE + 16'(i + 1) >= list_start)
            && (SLOT_BASE + 16'(i + 1) <= list_end);
    end

    // A list may not change under a running scan.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_reg <= '0;
            reject_reg <= 1'b0;
        end
        else if (wr && paddr == SCAN_LIST_OFS && !busy)
        begin
            reject_reg <= ~list_ok;
            if (list_ok)
                mask_reg <= mask_next;
        end
    end

    // ********************************************************
    // Scan sequencer
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= scan_idle;
            idx_reg <= CH_IDX_PORT0;
        end
        else
        begin
            case (state_reg)
                scan_idle:
                    if (wr && paddr == SCAN_CTRL_OFS && pwdata[SCAN_BUSY_BIT])
                    begin
                        state_reg <= scan_run;
                        idx_reg <= CH_IDX_PORT0;
                    end
                scan_run:
                    if (idx_reg == CH_IDX_COUNT)
                        state_reg <= scan_idle;
                    else
                        idx_reg <= idx_reg + 2'h1;
                default:
                    state_reg <= scan_idle;
            endcase
        end
    end

    // Scan steps read, and the count step can clear the counter; no port latch or DAC code is touched here.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_dio_reg <= '0;
            scan_count_reg <= '0;
        end
        else if (busy && mask_reg[idx_reg])
        begin
            if (idx_reg == CH_IDX_PORT0)
                scan_dio_reg[7:0] <= live0;
            if (idx_reg == CH_IDX_PORT1)
                scan_dio_reg[15:8] <= live1;
            if (idx_reg == CH_IDX_COUNT)
                scan_count_reg <= count;
        end
    end

    assign scan_clear = busy && idx_reg == CH_IDX_COUNT && mask_reg[CH_IDX_COUNT]
        && ctrl_reg[CTRL_CLR_MODE_BIT];

    // ********************************************************
    // Checks
    // ********************************************************
    plain_read_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && paddr == COUNT_OFS && !scan_clear) |-> !u_counter.clear)
        else $error("Plain count read cleared the counter.");
    clear_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && paddr == COUNT_CLR_OFS)
        |=> prdata[25:0] == $past(count) && count < COUNT_W'(2))
        else $error("Clearing read did not return the count.");
    scan_clear_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && idx_reg == CH_IDX_COUNT && mask_reg[2] && !bus_clear)
        |-> u_counter.clear == ctrl_reg[CTRL_CLR_MODE_BIT])
        else $error("Scan clear ignored the mode.");
    word_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == WORD_OFS) |=> {port1_o, port0_o} == $past(pwdata[15:0]))
        else $error("Word write did not drive both ports.");
    scan_no_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && !wr) |=> $stable(dac0_code) && $stable(dac1_code) && $stable(port0_o) && $stable(port1_o))
        else $error("Scan changed an output.");
    reject_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == SCAN_LIST_OFS && !busy && !list_ok) |=> reject_reg && $stable(mask_reg))
        else $error("Bad endpoint not rejected.");
    force_input_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == SCAN_LIST_OFS && !busy && list_ok && mask_next[0] && !mask_next[1])
        |=> !dir_reg[0] && dir_reg[1] == $past(dir_reg[1]))
        else $error("Scanned port not forced to input.");
    live_word_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && paddr == WORD_OFS) |=> prdata[15:0] == {$past(live1), $past(live0)})
        else $error("Word read not live.");
    sweep_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(busy) |-> busy [*3] ##1 !busy)
        else $error("Sweep not three steps.");
    scan_cnt_c: cover property (@(posedge pclk) disable iff (!presetn) scan_clear);
    clr_edge_c: cover property (@(posedge pclk) disable iff (!presetn) bus_clear && u_counter.hit);
    reject_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(reject_reg));
endmodule

// [src/totalizer_pkg.sv]
// Constants shared by the event totalizer and digital I/O block.
// Assumes a 32-bit APB slave with word-aligned registers.
package totalizer_pkg;
    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] COUNT_OFS = 8'h04;
    localparam logic [7:0] COUNT_CLR_OFS = 8'h08;
    localparam logic [7:0] DIR_OFS = 8'h0C;
    localparam logic [7:0] PORT0_OFS = 8'h10;
    localparam logic [7:0] PORT1_OFS = 8'h14;
    localparam logic [7:0] WORD_OFS = 8'h18;
    localparam logic [7:0] DAC0_OFS = 8'h1C;
    localparam logic [7:0] DAC1_OFS = 8'h20;
    localparam logic [7:0] SCAN_LIST_OFS = 8'h24;
    localparam logic [7:0] SCAN_CTRL_OFS = 8'h28;
    localparam logic [7:0] SCAN_DIO_OFS = 8'h2C;
    localparam logic [7:0] SCAN_COUNT_OFS = 8'h30;
    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int CTRL_EDGE_BIT = 0;
    localparam int CTRL_CLR_MODE_BIT = 1;
    localparam int SCAN_BUSY_BIT = 0;
    localparam int SCAN_REJECT_BIT = 1;
    localparam int LIST_END_LSB = 16;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] DIR_RESET = 2'h0;
    localparam logic [15:0] DAC_RESET = 16'h0000;
    // ********************************************************
    // Counter and channel numbering
    // ********************************************************
    localparam int COUNT_W = 26;
    localparam logic [25:0] COUNT_MAX = 26'h3FFFFFF;
    localparam int PORT_W = 8;
    localparam int SCAN_CH = 3;
    localparam logic [15:0] DEFAULT_SLOT = 16'h0064;
    localparam logic [1:0] CH_IDX_PORT0 = 2'h0;
    localparam logic [1:0] CH_IDX_PORT1 = 2'h1;
    localparam logic [1:0] CH_IDX_COUNT = 2'h2;
    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_HZ = 25000000;
    localparam int MAX_EVENT_HZ = 100000;
    localparam int CYCLES_PER_EVENT = CLK_HZ / MAX_EVENT_HZ;
    typedef enum logic [0:0] {scan_idle, scan_run} scan_state_e;
endpackage

// [src/event_counter.sv]
// Edge counter with input synchroniser and lossless clear.
// Assumes evt_pin is asynchronous to pclk and edges are spaced by at least 2 clocks.
`timescale 1ns/1ns
module event_counter
#(
    parameter int WIDTH = totalizer_pkg::COUNT_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic evt_pin,
    input wire logic edge_falling,
    input wire logic clear,
    output logic [WIDTH-1:0] count
);
    import totalizer_pkg::*;

    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;
    logic hit;
    logic [WIDTH-1:0] count_reg;

    // ********************************************************
    // Synchroniser and edge detect
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= evt_pin;
            sync2_reg <= sync1_reg;
            last_reg <= sync2_reg;
        end
    end

    // Only the second and third stages are compared, so each edge gives one hit.
    assign hit = edge_falling ? (last_reg & ~sync2_reg) : (~last_reg & sync2_reg);

    // ********************************************************
    // Count
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_reg <= '0;
        else if (clear)
            count_reg <= hit ? WIDTH'(1) : '0;
        else if (hit)
            count_reg <= count_reg + WIDTH'(1);
    end

    assign count = count_reg;

    wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (hit && !clear && count_reg == COUNT_MAX) |=> count_reg == '0)
        else $error("Counter did not wrap to zero.");
    clear_keeps_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clear && hit) |=> count_reg == WIDTH'(1))
        else $error("Edge lost during clear.");
    edge_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        (hit && !clear) |=> !hit && count_reg == $past(count_reg) + WIDTH'(1))
        else $error("Edge counted other than once.");
    select_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(sync2_reg) && !edge_falling && !clear && count_reg != COUNT_MAX)
        |=> count_reg == $past(count_reg) + WIDTH'(1))
        else $error("Rising edge not counted.");
endmodule

// [src/dio_port.sv]
// One bidirectional digital port: output latch, direction, synchronised pins.
// Assumes pins are asynchronous; the pad combines pin_o and pin_oe.
`timescale 1ns/1ns
module dio_port
#(
    parameter int WIDTH = totalizer_pkg::PORT_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic drive,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] live
);
    import totalizer_pkg::*;

    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] sync1_reg;
    logic [WIDTH-1:0] sync2_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_reg <= '0;
        else if (wr_en)
            out_reg <= wr_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    assign pin_o = out_reg;
    assign pin_oe = {WIDTH{drive}};
    assign live = sync2_reg;
endmodule

// [bench/pulse_line_model.sv]
// Far-side model: an event pulse source and the pins of both digital ports.
// Assumes requests come from the bench right after a rising pclk edge.
`timescale 1ns/1ns
module pulse_line_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic [15:0] n_pulses,
    input wire logic slow,
    output logic busy,
    output logic evt_pin,
    input wire logic [7:0] ext0,
    input wire logic [7:0] ext1,
    input wire logic [7:0] port0_o,
    input wire logic [7:0] port0_oe,
    input wire logic [7:0] port1_o,
    input wire logic [7:0] port1_oe,
    output logic [7:0] port0_i,
    output logic [7:0] port1_i
);
    logic [3:0] t;
    logic [15:0] left;
    logic [3:0] hold;
    // ********************************************************
    // Pin resolution
    // ********************************************************
    // A driven bit shows the device's latch, an undriven bit shows the outside level.
    assign port0_i = (port0_o & port0_oe) | (ext0 & ~port0_oe);
    assign port1_i = (port1_o & port1_oe) | (ext1 & ~port1_oe);
    // ********************************************************
    // Pulse train
    // ********************************************************
    // Each level is held two cycles or more, so fast pulses stay at the legal limit.
    assign hold = slow ? 4'h6 : 4'h2;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_pin <= 1'b0;
            busy <= 1'b0;
            t <= 4'h0;
            left <= 16'h0000;
        end
        else if (!busy)
        begin
            if (req && n_pulses != 16'h0000)
            begin
                busy <= 1'b1;
                left <= n_pulses;
                t <= 4'h0;
            end
        end
        else if (t < hold - 4'h1)
            t <= t + 4'h1;
        else
        begin
            t <= 4'h0;
            evt_pin <= ~evt_pin;
            if (evt_pin)
            begin
                left <= left - 16'h0001;
                busy <= (left != 16'h0001);
            end
        end
    end
endmodule

// [bench/event_totalizer_digital_io_tb_top.sv]
// Self-checking bench for the totalizer, digital ports, DAC codes and scan.
// Assumes the default slot base and a zero-wait APB slave.
`timescale 1ns/1ns
module event_totalizer_digital_io_tb_top;
    import totalizer_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, evt_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] p0_i, p0_o, p0_oe, p1_i, p1_o, p1_oe, ext0, ext1;
    logic [15:0] dac0_code, dac1_code, n_pulses;
    logic req, slow, busy, err;
    int errors = 0;
    int n_tests = 0;
    event_totalizer_digital_io i_event_totalizer_digital_io (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt_pin(evt_pin), .port0_i(p0_i), .port0_o(p0_o), .port0_oe(p0_oe), .port1_i(p1_i),
        .port1_o(p1_o), .port1_oe(p1_oe), .dac0_code(dac0_code), .dac1_code(dac1_code));
    pulse_line_model i_pulse_line_model (.pclk(pclk), .presetn(presetn), .req(req), .n_pulses(n_pulses),
        .slow(slow), .busy(busy), .evt_pin(evt_pin), .ext0(ext0), .ext1(ext1), .port0_o(p0_o),
        .port0_oe(p0_oe), .port1_o(p1_o), .port1_oe(p1_oe), .port0_i(p0_i), .port1_i(p1_i));
    // ********************************************************
    // Clock, reset and watchdog
    // ********************************************************
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        conclude();
    end
    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic conclude();
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // The request is held until pready is sampled high; data and error are taken at that edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulses(input logic [15:0] n, input logic s);
        @(posedge pclk);
        req <= 1'b1;
        n_pulses <= n;
        slow <= s;
        @(posedge pclk);
        req <= 1'b0;
        // The model raises busy at the edge that takes req, so look one edge later.
        @(posedge pclk);
        repeat (400) if (busy !== 1'b0) @(posedge pclk);
        // The synchroniser and edge compare need three edges before the count moves.
        repeat (6) @(posedge pclk);
    endtask
    task automatic run_scan();
        apb(1'b1, SCAN_CTRL_OFS, 32'h0000_0001);
        repeat (10) begin apb(1'b0, SCAN_CTRL_OFS, 32'h0); if (rd[SCAN_BUSY_BIT] === 1'b0) break; end
        check("scan idle", {31'h0, rd[SCAN_BUSY_BIT]}, 32'h0);
    endtask
    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_reset_and_unmapped();
        apb(1'b0, CTRL_OFS, 32'h0); check("ctrl reset", rd, 32'h0);
        apb(1'b0, DIR_OFS, 32'h0); check("dir reset", rd, 32'h0);
        apb(1'b0, COUNT_OFS, 32'h0); check("count reset", rd, 32'h0);
        check("oe reset", {16'h0, p1_oe, p0_oe}, 32'h0);
        apb(1'b1, 8'h40, 32'h0000_00FF); check("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h40, 32'h0); check("unmapped data", rd, 32'h0);
    endtask
    task automatic t_count_edges();
        pulses(16'h0005, 1'b0);
        apb(1'b0, COUNT_OFS, 32'h0); check("rising count", rd, 32'h5);
        apb(1'b0, COUNT_OFS, 32'h0); check("plain read keeps", rd, 32'h5);
        apb(1'b0, COUNT_CLR_OFS, 32'h0); check("clearing read", rd, 32'h5);
        apb(1'b0, COUNT_OFS, 32'h0); check("after clear", rd, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        pulses(16'h0003, 1'b1);
        apb(1'b0, COUNT_OFS, 32'h0); check("falling count", rd, 32'h3);
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b0, COUNT_CLR_OFS, 32'h0);
    endtask
    task automatic t_ports_and_dac();
        ext0 <= 8'hA5;
        ext1 <= 8'h3C;
        repeat (4) @(posedge pclk);
        apb(1'b0, PORT0_OFS, 32'h0); check("port0 live", rd, 32'hA5);
        apb(1'b0, PORT1_OFS, 32'h0); check("port1 live", rd, 32'h3C);
        apb(1'b0, WORD_OFS, 32'h0); check("word read", rd, 32'h3CA5);
        apb(1'b1, DIR_OFS, 32'h0000_0003);
        apb(1'b1, WORD_OFS, 32'h0000_1234);
        // The write lands at the edge the task returns on, so let it settle.
        @(posedge pclk);
        check("word drive", {p1_oe, p0_oe, p1_o, p0_o}, 32'hFFFF_1234);
        repeat (4) @(posedge pclk);
        apb(1'b0, WORD_OFS, 32'h0); check("driven pins", rd, 32'h1234);
        apb(1'b1, DAC0_OFS, 32'h0000_8000);
        apb(1'b1, DAC1_OFS, 32'h0000_7FFF);
        @(posedge pclk);
        check("dac codes", {dac1_code, dac0_code}, 32'h7FFF_8000);
    endtask
    task automatic t_scan();
        apb(1'b1, SCAN_LIST_OFS, {DEFAULT_SLOT + 16'h5, DEFAULT_SLOT + 16'h1});
        apb(1'b0, SCAN_CTRL_OFS, 32'h0); check("bad end", {31'h0, rd[SCAN_REJECT_BIT]}, 32'h1);
        apb(1'b1, SCAN_LIST_OFS, {DEFAULT_SLOT + 16'h1, DEFAULT_SLOT + 16'h3});
        apb(1'b0, SCAN_CTRL_OFS, 32'h0); check("start above end", {31'h0, rd[SCAN_REJECT_BIT]}, 32'h1);
        apb(1'b1, SCAN_LIST_OFS, {DEFAULT_SLOT + 16'h1, DEFAULT_SLOT + 16'h1});
        apb(1'b0, SCAN_CTRL_OFS, 32'h0); check("good list", {31'h0, rd[SCAN_REJECT_BIT]}, 32'h0);
        apb(1'b0, DIR_OFS, 32'h0); check("port0 input only", rd, 32'h2);
        apb(1'b1, SCAN_LIST_OFS, {DEFAULT_SLOT + 16'h3, DEFAULT_SLOT + 16'h1});
        apb(1'b0, SCAN_LIST_OFS, 32'h0); check("list mask", rd, 32'h7);
        apb(1'b0, DIR_OFS, 32'h0); check("both inputs", rd, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h0000_0002);
        pulses(16'h0004, 1'b0);
        run_scan();
        apb(1'b0, SCAN_COUNT_OFS, 32'h0); check("scan count", rd, 32'h4);
        apb(1'b0, COUNT_OFS, 32'h0); check("scan cleared", rd, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h0);
        pulses(16'h0002, 1'b0);
        run_scan();
        apb(1'b0, SCAN_COUNT_OFS, 32'h0); check("scan count kept", rd, 32'h2);
        apb(1'b0, COUNT_OFS, 32'h0); check("no scan clear", rd, 32'h2);
        apb(1'b0, SCAN_DIO_OFS, 32'h0); check("scan ports", rd, 32'h3CA5);
        check("scan no writes", {dac0_code, p1_o, p0_o}, 32'h8000_1234);
    endtask
    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, req, slow} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_pulses = 16'h0000;
        ext0 = 8'h00;
        ext1 = 8'h00;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_and_unmapped();
        t_count_edges();
        t_ports_and_dac();
        t_scan();
        conclude();
    end
endmodule
